// File: inc/vmm_pkg.sv
/*
  Shared constants for the vector select, count and copy datapath: lane
  layout, opcode values, index-load limits and reset values.
  Assumes one core clock and opcodes taken from the two-source encoding.
*/
package vmm_pkg;

  localparam int LANES     = 4;
  localparam int OP_W      = 11;
  localparam int DATA_W    = 32;
  localparam int POS_W     = 6;
  localparam int CNT_W     = 7;
  localparam int INDEX_W   = 9;
  localparam int SP_EXP_W  = 8;
  localparam int DP_EXP_W  = 11;

  // lane numbering: x is lane 0, w is lane 3
  localparam int LANE_X    = 0;
  localparam int LANE_Y    = 1;
  localparam int LANE_Z    = 2;
  localparam int LANE_W    = 3;

  typedef logic [OP_W-1:0] vmm_op_type;

  localparam vmm_op_type OP_FLOAT_PRODUCT          = 11'h001;
  localparam vmm_op_type OP_FLOAT_LESSER           = 11'h004;
  localparam vmm_op_type OP_FLOAT_GREATER_NAN_AWARE = 11'h005;
  localparam vmm_op_type OP_FLOAT_LESSER_NAN_AWARE = 11'h006;
  localparam vmm_op_type OP_COPY                   = 11'h019;
  localparam vmm_op_type OP_NO_OPERATION           = 11'h01a;
  localparam vmm_op_type OP_SIGNED_GREATER_PICK    = 11'h036;
  localparam vmm_op_type OP_SIGNED_LESSER_PICK     = 11'h037;
  localparam vmm_op_type OP_UNSIGNED_GREATER_PICK  = 11'h038;
  localparam vmm_op_type OP_UNSIGNED_LESSER_PICK   = 11'h039;
  localparam vmm_op_type OP_UPPER_HALF_LANE_POPCOUNT = 11'h0b3;
  localparam vmm_op_type OP_LOWER_HALF_POPCOUNT_CHAIN = 11'h0b7;
  localparam vmm_op_type OP_DOUBLE_LESSER_PICK     = 11'h0bc;
  localparam vmm_op_type OP_DOUBLE_GREATER_PICK    = 11'h0bd;
  localparam vmm_op_type OP_QUAD_LANE_GREATEST     = 11'h0c1;
  localparam vmm_op_type OP_INDEX_REG_LOAD_CLAMPED = 11'h0cc;

  localparam logic signed [31:0] INDEX_LOW          = -32'sd256;
  localparam logic signed [31:0] INDEX_HIGH         = 32'sd255;
  localparam logic [INDEX_W-1:0] INDEX_OUT_OF_RANGE = 9'h100;
  localparam logic [INDEX_W-1:0] INDEX_RESET        = 9'h000;
  localparam logic [DATA_W-1:0]  RESULT_RESET       = 32'h0000_0000;

  localparam logic [7:0]  SP_EXP_ONES = 8'hff;
  localparam logic signed [9:0] SP_BIAS = 10'sd127;
  localparam logic signed [9:0] SP_EXP_LIMIT = 10'sd255;

endpackage

// File: src/vmm_fp_order.sv
/*
  Ordering of two IEEE floating values of a given width: strict less-than
  both ways, NaN flags and a flag for two zeros of any sign.
  Assumes operands arrive from logic on the same clock; purely combinational.
*/
`timescale 1ns/100ps
module vmm_fp_order #(
  parameter int W  = 32,
  parameter int EW = 8
) (
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  output logic              a_lt_b,
  output logic              b_lt_a,
  output logic              a_nan,
  output logic              b_nan,
  output logic              both_zero
);

  logic [W-1:0] key_a;
  logic [W-1:0] key_b;
  logic         any_nan;

  assign a_nan = (&a[W-2:W-1-EW]) && (|a[W-2-EW:0]);
  assign b_nan = (&b[W-2:W-1-EW]) && (|b[W-2-EW:0]);
  assign any_nan = a_nan || b_nan;
  assign both_zero = (a[W-2:0] == '0) && (b[W-2:0] == '0);

  // map sign-magnitude onto an unsigned order
  assign key_a = a[W-1] ? ~a : {1'b1, a[W-2:0]};
  assign key_b = b[W-1] ? ~b : {1'b1, b[W-2:0]};

  // unordered and equal zeros compare false
  assign a_lt_b = !any_nan && !both_zero && (key_a < key_b);
  assign b_lt_a = !any_nan && !both_zero && (key_b < key_a);

endmodule

// File: src/vmm_popcount.sv
/*
  Count of set bits in one 32-bit word.
  Assumes the word is already masked by the caller; purely combinational.
*/
`timescale 1ns/100ps
module vmm_popcount
  import vmm_pkg::*;
(
  input  wire logic [DATA_W-1:0] bits,
  output logic [CNT_W-1:0]       count
);

  always_comb begin
    count = '0;
    for (int i = 0; i < DATA_W; i++) begin
      count = count + CNT_W'(bits[i]);
    end
  end

endmodule

// File: src/vmm_lane_alu.sv
/*
  Four-lane vector datapath: float, signed, unsigned and double select,
  quad-lane greatest, masked lane popcount chain, copy, float product
  and clamped index-register load, with the previous-result bypass state.
  Assumes the issue logic presents one instruction group per valid cycle,
  all inputs from the core clock domain; results appear one cycle later.
*/
// Contract
// - float greater nan-aware, opcode 5, picks >=
// - signed greater pick, opcode 54, >=
// - unsigned greater pick, opcode 56, >=
// - opcode 193: max of four lanes, replicated
// - quad max kept only in x, bypassed
// - opcode 179 counts src0 under mask high half
// - opcode 183 counts low half plus previous
// - chain never in w; takes next-higher lane
// - float lesser, opcode 4, strict less-than
// - double lesser, opcode 188, min zero negative
// - double greater decoded from opcode 189
// - double greater strict, max zero positive
// - float lesser nan-aware, opcode 6, strict
// - signed lesser pick, opcode 55, strict
// - unsigned lesser pick, opcode 57, strict
// - copy, opcode 25, passes src0 unchanged
// - masked copy keeps bypass, no-op clears
// - opcode 204 clamps to index register
// - out of range gives 0x100, result undefined
// - float product, zero times anything is zero
// - float product decoded from opcode 1
`timescale 1ns/100ps
module vmm_lane_alu
  import vmm_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  input  wire logic               issue_valid,
  input  wire logic [OP_W-1:0]    op_code_field [LANES],
  input  wire logic [DATA_W-1:0]  src0 [LANES],
  input  wire logic [DATA_W-1:0]  src1 [LANES],
  input  wire logic [LANES-1:0]   write_en,
  input  wire logic [POS_W-1:0]   thread_pos,
  output logic                    result_valid,
  output logic [DATA_W-1:0]       result [LANES],
  output logic [LANES-1:0]        result_write,
  output logic [DATA_W-1:0]       previous_vector_result [LANES],
  output logic [INDEX_W-1:0]      index_register,
  output logic                    index_valid,
  output logic                    illegal_group
);

  function automatic logic is_double(input logic [OP_W-1:0] op);
    is_double = (op == OP_DOUBLE_LESSER_PICK) ||
                (op == OP_DOUBLE_GREATER_PICK);
  endfunction

  // zero or denormal in either operand gives a signed zero
  function automatic logic [31:0] fmul_zero_safe(input logic [31:0] a,
                                                 input logic [31:0] b);
    logic              sgn;
    logic [7:0]        ea;
    logic [7:0]        eb;
    logic [47:0]       prod;
    logic signed [9:0] e;
    logic [22:0]       frac;
    sgn  = a[31] ^ b[31];
    ea   = a[30:23];
    eb   = b[30:23];
    prod = {1'b1, a[22:0]} * {1'b1, b[22:0]};
    e    = $signed({2'b00, ea}) + $signed({2'b00, eb}) - SP_BIAS;
    if (prod[47]) begin
      frac = prod[46:24];
      e    = e + 10'sd1;
    end else begin
      frac = prod[45:23];
    end
    if (ea == 8'h00 || eb == 8'h00) begin
      fmul_zero_safe = {sgn, 31'h0000_0000};
    end else if (ea == SP_EXP_ONES && a[22:0] != 23'h000000) begin
      fmul_zero_safe = a;
    end else if (eb == SP_EXP_ONES && b[22:0] != 23'h000000) begin
      fmul_zero_safe = b;
    end else if (ea == SP_EXP_ONES || eb == SP_EXP_ONES ||
                 e >= SP_EXP_LIMIT) begin
      fmul_zero_safe = {sgn, SP_EXP_ONES, 23'h000000};
    end else if (e <= 10'sd0) begin
      fmul_zero_safe = {sgn, 31'h0000_0000};
    end else begin
      fmul_zero_safe = {sgn, e[7:0], frac};
    end
  endfunction

  logic [LANES-1:0]  f_lt;
  logic [LANES-1:0]  f_gt;
  logic [LANES-1:0]  f_a_nan;
  logic [LANES-1:0]  f_b_nan;
  logic [CNT_W-1:0]  lane_cnt [LANES];
  logic [CNT_W-1:0]  chain_in [LANES];
  logic [63:0]       thread_mask;
  logic [DATA_W-1:0] next_result [LANES];
  logic [DATA_W-1:0] pv [LANES];
  logic              pv_quad;

  assign thread_mask = (64'h1 << thread_pos) - 64'h1;

  generate
    for (genvar i = 0; i < LANES; i++) begin : g_lane
      logic [DATA_W-1:0] masked;

      vmm_fp_order #(.W(DATA_W), .EW(SP_EXP_W)) u_order (
        .a         (src0[i]),
        .b         (src1[i]),
        .a_lt_b    (f_lt[i]),
        .b_lt_a    (f_gt[i]),
        .a_nan     (f_a_nan[i]),
        .b_nan     (f_b_nan[i]),
        .both_zero ()
      );

      // upper half for the high count, lower half otherwise
      assign masked = (op_code_field[i] == OP_UPPER_HALF_LANE_POPCOUNT)
                    ? (thread_mask[63:32] & src0[i])
                    : (thread_mask[31:0] & src0[i]);

      vmm_popcount u_count (
        .bits  (masked),
        .count (lane_cnt[i])
      );

      // chain input comes from the next-higher lane; w has none
      if (i == LANE_W) begin : g_top
        assign chain_in[i] = '0;
      end else begin : g_chain
        assign chain_in[i] = lane_cnt[i+1];
      end
    end
  endgenerate

  // quad-lane greatest: pairwise >= tree over the four src0 words
  logic [DATA_W-1:0] q_lo;
  logic [DATA_W-1:0] q_hi;
  logic [DATA_W-1:0] q_max;
  logic [2:0]        q_lt;
  logic [2:0]        q_anan;
  logic [2:0]        q_bnan;

  vmm_fp_order #(.W(DATA_W), .EW(SP_EXP_W)) u_quad_lo (
    .a (src0[LANE_X]), .b (src0[LANE_Y]), .a_lt_b (q_lt[0]),
    .b_lt_a (), .a_nan (q_anan[0]), .b_nan (q_bnan[0]), .both_zero ()
  );
  vmm_fp_order #(.W(DATA_W), .EW(SP_EXP_W)) u_quad_hi (
    .a (src0[LANE_Z]), .b (src0[LANE_W]), .a_lt_b (q_lt[1]),
    .b_lt_a (), .a_nan (q_anan[1]), .b_nan (q_bnan[1]), .both_zero ()
  );
  vmm_fp_order #(.W(DATA_W), .EW(SP_EXP_W)) u_quad_top (
    .a (q_lo), .b (q_hi), .a_lt_b (q_lt[2]),
    .b_lt_a (), .a_nan (q_anan[2]), .b_nan (q_bnan[2]), .both_zero ()
  );

  assign q_lo  = (!q_lt[0] && !q_anan[0] && !q_bnan[0])
               ? src0[LANE_X] : src0[LANE_Y];
  assign q_hi  = (!q_lt[1] && !q_anan[1] && !q_bnan[1])
               ? src0[LANE_Z] : src0[LANE_W];
  assign q_max = (!q_lt[2] && !q_anan[2] && !q_bnan[2])
               ? q_lo : q_hi;

  // double pairs: yx is pair 0, wz is pair 1
  logic [63:0] d_a [2];
  logic [63:0] d_b [2];
  logic [63:0] d_res [2];
  logic [1:0]  d_lt;
  logic [1:0]  d_gt;
  logic [1:0]  d_zero;

  generate
    for (genvar p = 0; p < 2; p++) begin : g_pair
      assign d_a[p] = {src0[2*p+1], src0[2*p]};
      assign d_b[p] = {src1[2*p+1], src1[2*p]};

      vmm_fp_order #(.W(64), .EW(DP_EXP_W)) u_dorder (
        .a         (d_a[p]),
        .b         (d_b[p]),
        .a_lt_b    (d_lt[p]),
        .b_lt_a    (d_gt[p]),
        .a_nan     (),
        .b_nan     (),
        .both_zero (d_zero[p])
      );

      always_comb begin
        if (op_code_field[2*p] == OP_DOUBLE_LESSER_PICK) begin
          if (d_zero[p]) begin
            d_res[p] = {d_a[p][63] | d_b[p][63], 63'h0};
          end else begin
            d_res[p] = d_lt[p] ? d_a[p] : d_b[p];
          end
        end else begin
          if (d_zero[p]) begin
            d_res[p] = {d_a[p][63] & d_b[p][63], 63'h0};
          end else begin
            d_res[p] = d_gt[p] ? d_a[p] : d_b[p];
          end
        end
      end
    end
  endgenerate

  // per-lane result selection
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      case (op_code_field[i])
        OP_FLOAT_PRODUCT: begin
          next_result[i] = fmul_zero_safe(src0[i], src1[i]);
        end
        OP_FLOAT_LESSER: begin
          next_result[i] = f_lt[i] ? src0[i] : src1[i];
        end
        OP_FLOAT_GREATER_NAN_AWARE: begin
          if (f_a_nan[i] && !f_b_nan[i]) begin
            next_result[i] = src1[i];
          end else if (f_b_nan[i] && !f_a_nan[i]) begin
            next_result[i] = src0[i];
          end else begin
            next_result[i] = (!f_lt[i] && !f_a_nan[i])
                           ? src0[i] : src1[i];
          end
        end
        OP_FLOAT_LESSER_NAN_AWARE: begin
          if (f_a_nan[i] && !f_b_nan[i]) begin
            next_result[i] = src1[i];
          end else if (f_b_nan[i] && !f_a_nan[i]) begin
            next_result[i] = src0[i];
          end else begin
            next_result[i] = f_lt[i] ? src0[i] : src1[i];
          end
        end
        OP_SIGNED_GREATER_PICK: begin
          next_result[i] = ($signed(src0[i]) >= $signed(src1[i]))
                         ? src0[i] : src1[i];
        end
        OP_SIGNED_LESSER_PICK: begin
          next_result[i] = ($signed(src0[i]) < $signed(src1[i]))
                         ? src0[i] : src1[i];
        end
        OP_UNSIGNED_GREATER_PICK: begin
          next_result[i] = (src0[i] >= src1[i]) ? src0[i] : src1[i];
        end
        OP_UNSIGNED_LESSER_PICK: begin
          next_result[i] = (src0[i] < src1[i]) ? src0[i] : src1[i];
        end
        OP_COPY: begin
          next_result[i] = src0[i];
        end
        OP_UPPER_HALF_LANE_POPCOUNT: begin
          next_result[i] = DATA_W'(lane_cnt[i]);
        end
        OP_LOWER_HALF_POPCOUNT_CHAIN: begin
          next_result[i] = DATA_W'(lane_cnt[i] + chain_in[i]);
        end
        OP_DOUBLE_LESSER_PICK, OP_DOUBLE_GREATER_PICK: begin
          // lanes of a pair take their own half
          next_result[i] = i[0] ? d_res[i/2][63:32] : d_res[i/2][31:0];
        end
        OP_QUAD_LANE_GREATEST: begin
          next_result[i] = q_max;
        end
        default: begin
          // index load leaves its result undefined; driven as zero
          next_result[i] = RESULT_RESET;
        end
      endcase
    end
  end

  // clamped index load, lowest lane carrying the opcode wins
  logic                next_index_hit;
  logic [INDEX_W-1:0]  next_index;
  logic signed [31:0]  index_src;

  always_comb begin
    next_index_hit = 1'b0;
    index_src      = '0;
    for (int i = LANES - 1; i >= 0; i--) begin
      if (op_code_field[i] == OP_INDEX_REG_LOAD_CLAMPED) begin
        next_index_hit = 1'b1;
        index_src      = $signed(src0[i]);
      end
    end
    if (index_src < INDEX_LOW || index_src > INDEX_HIGH) begin
      next_index = INDEX_OUT_OF_RANGE;
    end else begin
      next_index = index_src[INDEX_W-1:0];
    end
  end

  // group misuse: chain in w, or quad max not in every lane
  logic next_illegal;
  logic quad_any;
  logic quad_all;

  always_comb begin
    quad_any = 1'b0;
    quad_all = 1'b1;
    for (int i = 0; i < LANES; i++) begin
      quad_any = quad_any || (op_code_field[i] == OP_QUAD_LANE_GREATEST);
      quad_all = quad_all && (op_code_field[i] == OP_QUAD_LANE_GREATEST);
    end
    next_illegal = (op_code_field[LANE_W] == OP_LOWER_HALF_POPCOUNT_CHAIN)
                 || (quad_any && !quad_all);
  end

  // registered results
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      result_valid <= 1'b0;
      result_write <= '0;
      for (int i = 0; i < LANES; i++) begin
        result[i] <= RESULT_RESET;
      end
    end else begin
      result_valid <= issue_valid;
      for (int i = 0; i < LANES; i++) begin
        result_write[i] <= issue_valid && write_en[i] &&
                           (op_code_field[i] != OP_NO_OPERATION);
        if (issue_valid) begin
          result[i] <= next_result[i];
        end
      end
    end
  end

  // previous-result bypass state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pv_quad <= 1'b0;
      for (int i = 0; i < LANES; i++) begin
        pv[i] <= RESULT_RESET;
      end
    end else if (issue_valid) begin
      pv_quad <= (op_code_field[LANE_X] == OP_QUAD_LANE_GREATEST);
      for (int i = 0; i < LANES; i++) begin
        if (op_code_field[i] == OP_NO_OPERATION) begin
          pv[i] <= RESULT_RESET;
        end else if (op_code_field[i] == OP_COPY && !write_en[i]) begin
          pv[i] <= pv[i];
        end else if (op_code_field[i] == OP_QUAD_LANE_GREATEST) begin
          if (i == LANE_X) begin
            pv[i] <= next_result[i];
          end
        end else begin
          pv[i] <= next_result[i];
        end
      end
    end
  end

  // after a quad max every lane forwards the x copy
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      previous_vector_result[i] = pv_quad ? pv[LANE_X] : pv[i];
    end
  end

  // index register and misuse flag
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      index_register <= INDEX_RESET;
      index_valid    <= 1'b0;
      illegal_group  <= 1'b0;
    end else begin
      index_valid   <= issue_valid && next_index_hit;
      illegal_group <= issue_valid && next_illegal;
      if (issue_valid && next_index_hit) begin
        index_register <= next_index;
      end
    end
  end

endmodule

// File: test/vmm_lane_alu_props.sv
/*
  Port checker for the four-lane select, count and copy datapath.
  Assumes the core clock domain only and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module vmm_lane_alu_props
  import vmm_pkg::*;
(
  input wire logic                core_clk,
  input wire logic                sys_rst,
  input wire logic                issue_valid,
  input wire logic [OP_W-1:0]     op_code_field [LANES],
  input wire logic [DATA_W-1:0]   src0 [LANES],
  input wire logic [DATA_W-1:0]   src1 [LANES],
  input wire logic [LANES-1:0]    write_en,
  input wire logic [POS_W-1:0]    thread_pos,
  input wire logic                result_valid,
  input wire logic [DATA_W-1:0]   result [LANES],
  input wire logic [LANES-1:0]    result_write,
  input wire logic [DATA_W-1:0]   previous_vector_result [LANES],
  input wire logic [INDEX_W-1:0]  index_register,
  input wire logic                index_valid,
  input wire logic                illegal_group
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_op0(op);
    issue_valid && op_code_field[0] == op;
  endsequence
  sequence s_quad;
    s_op0(OP_QUAD_LANE_GREATEST) ##0
      op_code_field[3] == OP_QUAD_LANE_GREATEST;
  endsequence

  a_result_pulse: assert property (issue_valid |=> result_valid)
    else $error("no result one cycle after issue");
  a_idle_quiet: assert property (!issue_valid |=> !result_valid &&
    result_write == 4'h0 && $stable(result[0]))
    else $error("outputs moved without issue");
  a_uint_greater: assert property (
    s_op0(OP_UNSIGNED_GREATER_PICK) |=> result[0] == ((
    $past(src0[0]) >= $past(src1[0])) ? $past(src0[0]) : $past(src1[0])))
    else $error("unsigned greater pick wrong");
  a_sint_lesser: assert property (
    s_op0(OP_SIGNED_LESSER_PICK) |=> result[0] == (($signed($past(src0[0]))
    < $signed($past(src1[0]))) ? $past(src0[0]) : $past(src1[0])))
    else $error("signed lesser pick wrong");
  a_copy_passes: assert property (s_op0(OP_COPY) |=>
    result[0] == $past(src0[0]) && result_write[0] == $past(write_en[0]))
    else $error("copy result wrong");
  a_masked_copy: assert property (s_op0(OP_COPY) ##0 !write_en[0] |=>
    previous_vector_result[0] == $past(previous_vector_result[0]))
    else $error("masked copy lost bypass value");
  a_nop_clears: assert property (
    s_op0(OP_NO_OPERATION) |=> previous_vector_result[0] == 32'h0)
    else $error("no-op kept bypass value");
  a_quad_bypass: assert property (s_quad |=>
    previous_vector_result[1] == previous_vector_result[0] &&
    previous_vector_result[3] == previous_vector_result[0] &&
    result[0] == previous_vector_result[0])
    else $error("quad greatest bypass not from x");
  a_chain_in_w: assert property (issue_valid &&
    op_code_field[3] == OP_LOWER_HALF_POPCOUNT_CHAIN |=> illegal_group)
    else $error("chain in w not flagged");
  a_index_range: assert property (
    s_op0(OP_INDEX_REG_LOAD_CLAMPED) ##0 ($signed(src0[0]) > INDEX_HIGH ||
    $signed(src0[0]) < INDEX_LOW) |=> index_valid &&
    index_register == INDEX_OUT_OF_RANGE)
    else $error("index load out of range not clamped");
endmodule

bind vmm_lane_alu vmm_lane_alu_props u_props (.*);

// File: test/vmm_issue_model.sv
/*
  Issue logic model: presents one instruction group per call.
  Assumes the caller stands at a falling edge of the core clock.
*/
`timescale 1ns/100ps
module vmm_issue_model
  import vmm_pkg::*;
(
  input  wire logic               core_clk,
  output logic                    issue_valid,
  output logic [OP_W-1:0]         op_code_field [LANES],
  output logic [DATA_W-1:0]       src0 [LANES],
  output logic [DATA_W-1:0]       src1 [LANES],
  output logic [LANES-1:0]        write_en,
  output logic [POS_W-1:0]        thread_pos
);
  initial begin
    issue_valid = 1'b0;
    write_en = 4'h0;
    thread_pos = 6'h00;
    op_code_field = '{4{11'h000}};
    src0 = '{4{32'h0}};
    src1 = '{4{32'h0}};
  end

  // held across exactly one rising edge; back to back if called again
  task automatic send(input vmm_op_type op [LANES],
                      input logic [31:0] a [LANES], b [LANES],
                      input logic [3:0] we, input logic [5:0] pos);
    issue_valid = 1'b1;
    op_code_field = op;
    src0 = a;
    src1 = b;
    write_en = we;
    thread_pos = pos;
    @(negedge core_clk);
  endtask

  // released lines show the inverse, never a stale value
  task automatic idle(input int n);
    issue_valid = 1'b0;
    foreach (src0[i]) begin
      src0[i] = ~src0[i];
      src1[i] = ~src1[i];
      op_code_field[i] = ~op_code_field[i];
    end
    write_en = ~write_en;
    thread_pos = ~thread_pos;
    repeat (n) @(negedge core_clk);
  endtask
endmodule

// File: test/vmm_lane_alu_tb.sv
/*
  Self-checking bench for the four-lane datapath.
  Assumes the issue model drives all inputs at falling edges.
*/
`timescale 1ns/100ps
module vmm_lane_alu_tb
  import vmm_pkg::*;
;
  logic               core_clk, sys_rst;
  logic               issue_valid, result_valid, index_valid, illegal_group;
  logic [OP_W-1:0]    op_code_field [LANES];
  logic [DATA_W-1:0]  src0 [LANES], src1 [LANES], result [LANES];
  logic [DATA_W-1:0]  pv [LANES], a [LANES], b [LANES], e [LANES];
  logic [LANES-1:0]   write_en, result_write;
  logic [POS_W-1:0]   thread_pos;
  logic [INDEX_W-1:0] index_register;
  vmm_op_type         ops [LANES];
  int                 n_mismatch = 0, comparisons = 0, cycles = 0;

  vmm_issue_model m (.core_clk(core_clk), .issue_valid(issue_valid),
    .op_code_field(op_code_field), .src0(src0), .src1(src1),
    .write_en(write_en), .thread_pos(thread_pos));
  vmm_lane_alu uut (.core_clk(core_clk), .sys_rst(sys_rst),
    .issue_valid(issue_valid), .op_code_field(op_code_field),
    .src0(src0), .src1(src1), .write_en(write_en),
    .thread_pos(thread_pos), .result_valid(result_valid),
    .result(result), .result_write(result_write),
    .previous_vector_result(pv), .index_register(index_register),
    .index_valid(index_valid), .illegal_group(illegal_group));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, exp);
    check({31'h0, got}, {31'h0, exp});
  endtask

  function automatic logic nan(input logic [31:0] x);
    return x[30:23] == 8'hff && x[22:0] != 23'h0;
  endfunction

  // strict float less-than for non-NaN values, zeros equal
  function automatic logic flt(input logic [31:0] x, y);
    if (x[31] != y[31]) return x[31] && (x[30:0] | y[30:0]) != 31'h0;
    return x[31] ? x[30:0] > y[30:0] : x[30:0] < y[30:0];
  endfunction

  function automatic logic [31:0] pick(input vmm_op_type op,
                                       input logic [31:0] x, y);
    logic one;
    one = nan(x) != nan(y);
    case (op)
      OP_FLOAT_LESSER: return !nan(x) && !nan(y) && flt(x, y) ? x : y;
      OP_FLOAT_GREATER_NAN_AWARE:
        return one ? (nan(x) ? y : x) : (nan(x) || flt(x, y)) ? y : x;
      OP_FLOAT_LESSER_NAN_AWARE:
        return one ? (nan(x) ? y : x) : (!nan(x) && flt(x, y)) ? x : y;
      OP_SIGNED_GREATER_PICK: return $signed(x) >= $signed(y) ? x : y;
      OP_SIGNED_LESSER_PICK: return $signed(x) < $signed(y) ? x : y;
      OP_UNSIGNED_GREATER_PICK: return x >= y ? x : y;
      default: return x < y ? x : y;
    endcase
  endfunction

  task automatic run(input logic [3:0] we, input logic [5:0] pos);
    m.send(ops, a, b, we, pos);
    check_flag(result_valid, 1'b1);
    foreach (e[i]) check(result[i], e[i]);
  endtask

  task automatic t_picks;
    vmm_op_type pl [7] = '{OP_FLOAT_LESSER, OP_FLOAT_GREATER_NAN_AWARE,
      OP_FLOAT_LESSER_NAN_AWARE, OP_SIGNED_GREATER_PICK,
      OP_SIGNED_LESSER_PICK, OP_UNSIGNED_GREATER_PICK,
      OP_UNSIGNED_LESSER_PICK};
    a = '{32'h0, 32'hffff_ffff, 32'h1, 32'h3f80_0000};
    b = '{32'h8000_0000, 32'h1, 32'h7fc0_0000, 32'hc000_0000};
    foreach (pl[k]) begin
      ops = '{4{pl[k]}};
      foreach (e[i]) e[i] = pick(pl[k], a[i], b[i]);
      run(4'hf, 6'(k));
      check({28'h0, result_write}, 32'hf);
      check_flag(illegal_group, 1'b0);
    end
    m.idle(1);
  endtask

  task automatic t_double;
    a = '{32'h0, 32'h0, 32'h0, 32'h3ff0_0000};
    b = '{32'h0, 32'h8000_0000, 32'h0, 32'h4000_0000};
    ops = '{4{OP_DOUBLE_LESSER_PICK}};
    e = '{32'h0, 32'h8000_0000, 32'h0, 32'h3ff0_0000};
    run(4'hf, 6'h00);
    ops = '{4{OP_DOUBLE_GREATER_PICK}};
    e = '{32'h0, 32'h0, 32'h0, 32'h4000_0000};
    run(4'hf, 6'h00);
    m.idle(1);
  endtask

  task automatic t_quad;
    ops = '{4{OP_QUAD_LANE_GREATEST}};
    a = '{32'h3f80_0000, 32'h4040_0000, 32'hc0a0_0000, 32'h4000_0000};
    e = '{4{32'h4040_0000}};
    run(4'hf, 6'h00);
    foreach (pv[i]) check(pv[i], 32'h4040_0000);
    m.idle(2);
  endtask

  task automatic t_popcount;
    logic [5:0] pl [6] = '{6'd0, 6'd1, 6'd31, 6'd32, 6'd33, 6'd63};
    logic [63:0] mk;
    int hi;
    ops = '{OP_LOWER_HALF_POPCOUNT_CHAIN, OP_UPPER_HALF_LANE_POPCOUNT,
            OP_COPY, OP_COPY};
    a = '{32'h0f0f_ffff, 32'hf0f0_f0f0, 32'h1234_5678, 32'h9abc_def0};
    foreach (pl[k]) begin
      mk = (64'h1 << pl[k]) - 64'h1;
      hi = $countones(a[1] & mk[63:32]);
      e = '{32'(hi + $countones(a[0] & mk[31:0])), 32'(hi), a[2], a[3]};
      run(4'hf, pl[k]);
    end
    ops[3] = OP_LOWER_HALF_POPCOUNT_CHAIN;
    e[3] = 32'($countones(a[3]));
    run(4'hf, 6'd63);
    check_flag(illegal_group, 1'b1);
    m.idle(1);
  endtask

  task automatic t_copy;
    ops = '{4{OP_COPY}};
    a = '{32'h1111_1111, 32'h2222_2222, 32'h3333_3333, 32'h4444_4444};
    e = a;
    run(4'hf, 6'h00);
    a = '{32'h5555_5555, 32'h6666_6666, 32'h7777_7777, 32'h8888_8888};
    e = a;
    run(4'he, 6'h00);
    check(pv[0], 32'h1111_1111);
    check(pv[1], 32'h6666_6666);
    check({28'h0, result_write}, 32'he);
    ops = '{4{OP_NO_OPERATION}};
    m.send(ops, a, b, 4'hf, 6'h00);
    check(pv[0], 32'h0);
    check({28'h0, result_write}, 32'h0);
    m.idle(1);
  endtask

  task automatic t_index;
    int v [6] = '{-257, -256, 255, 256, 0, -1};
    logic [8:0] x9 [6] = '{9'h100, 9'h100, 9'h0ff, 9'h100, 9'h000, 9'h1ff};
    ops = '{4{OP_INDEX_REG_LOAD_CLAMPED}};
    foreach (v[k]) begin
      a = '{32'(v[k]), 32'h7, 32'h7, 32'h7};
      m.send(ops, a, b, 4'(k), 6'(k));
      check_flag(index_valid, 1'b1);
      check({23'h0, index_register}, {23'h0, x9[k]});
      check(result[0], 32'h0);
    end
    m.idle(1);
    check_flag(index_valid, 1'b0);
    check({23'h0, index_register}, 32'h0000_01ff);
  endtask

  task automatic t_product;
    ops = '{4{OP_FLOAT_PRODUCT}};
    a = '{32'h0, 32'h4000_0000, 32'h8000_0000, 32'h3fc0_0000};
    b = '{32'h7f80_0000, 32'h4040_0000, 32'h7fc0_0000, 32'h3fc0_0000};
    e = '{32'h0, 32'h40c0_0000, 32'h8000_0000, 32'h4010_0000};
    run(4'hf, 6'h00);
    m.idle(1);
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      n_mismatch++;
      $display("Error at %0t: run took too long", $time);
      conclude();
    end
  end

  initial begin
    sys_rst = 1'b1;
    b = '{4{32'h0}};
    repeat (20) @(negedge core_clk);
    sys_rst = 1'b0;
    foreach (result[i]) check(result[i], 32'h0);
    check_flag(result_valid, 1'b0);
    $display("reset test done");
    t_picks();
    $display("pick test done");
    t_double();
    $display("double test done");
    t_quad();
    $display("quad test done");
    t_popcount();
    $display("popcount test done");
    t_copy();
    $display("copy test done");
    t_index();
    $display("index test done");
    t_product();
    $display("product test done");
    conclude();
  end
endmodule
